/* hw/cst_pkg.sv */
// How it works
// - Power-on reset delay by select bits: 50, 200 default, 400, 800 ms.
// - Watchdog period by select bits: 1.4 s, 200 ms, 25 ms, off default.
// - Watchdog reset time-out for selects 00 and 01 is 200 ms.
// - Watchdog reset time-out for select 10 is 25 ms.
// - Manual reset reaches the reset output no sooner than 500 ns.
// - Manual reset pulses under 500 ns are ignored.
// - Nonvolatile write cycle ends within 5 ms after a write stop.
// - On power-down the warning leads reset by about 500 ns.
// - Standby nine serial clocks after a start with wrong device select.
package cst_pkg;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned NS_PER_MS = 1000000;
	// Times in their own units
	localparam int unsigned POR_MS_0 = 50;
	localparam int unsigned POR_MS_1 = 200;
	localparam int unsigned POR_MS_2 = 400;
	localparam int unsigned POR_MS_3 = 800;
	localparam int unsigned WD_MS_0 = 1400;
	localparam int unsigned WD_MS_1 = 200;
	localparam int unsigned WD_MS_2 = 25;
	localparam int unsigned WD_TOUT_LONG_MS = 200;
	localparam int unsigned WD_TOUT_SHORT_MS = 25;
	localparam int unsigned NV_WRITE_MS = 5;
	localparam int unsigned MR_DELAY_NS = 500;
	localparam int unsigned WARN_LEAD_NS = 500;
	// Cycle counts at the bus clock
	localparam int unsigned POR_CYC_0 = POR_MS_0 * (NS_PER_MS / CLK_NS);
	localparam int unsigned POR_CYC_1 = POR_MS_1 * (NS_PER_MS / CLK_NS);
	localparam int unsigned POR_CYC_2 = POR_MS_2 * (NS_PER_MS / CLK_NS);
	localparam int unsigned POR_CYC_3 = POR_MS_3 * (NS_PER_MS / CLK_NS);
	localparam int unsigned WD_CYC_0 = WD_MS_0 * (NS_PER_MS / CLK_NS);
	localparam int unsigned WD_CYC_1 = WD_MS_1 * (NS_PER_MS / CLK_NS);
	localparam int unsigned WD_CYC_2 = WD_MS_2 * (NS_PER_MS / CLK_NS);
	localparam int unsigned TOUT_LONG_CYC = WD_TOUT_LONG_MS * (NS_PER_MS / CLK_NS);
	localparam int unsigned TOUT_SHORT_CYC = WD_TOUT_SHORT_MS * (NS_PER_MS / CLK_NS);
	localparam int unsigned NV_CYC = NV_WRITE_MS * (NS_PER_MS / CLK_NS);
	localparam logic [2:0] MR_CYC = 3'((MR_DELAY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] WARN_LEAD_CYC = 3'((WARN_LEAD_NS + CLK_NS - 1) / CLK_NS);
	// Register map
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] MASK_OFF = 8'h08;
	localparam logic [7:0] STATE_OFF = 8'h0c;
	localparam int unsigned POR_SEL_LO_BIT = 0;
	localparam int unsigned POR_SEL_HI_BIT = 1;
	localparam int unsigned WD_SEL_LO_BIT = 2;
	localparam int unsigned WD_SEL_HI_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'hd;
	localparam int unsigned EV_W = 6;
	localparam int unsigned EV_WDOG = 0;
	localparam int unsigned EV_MANUAL = 1;
	localparam int unsigned EV_SUPPLY_LOW_WARNING = 2;
	localparam int unsigned EV_SECOND = 3;
	localparam int unsigned EV_NV_DONE = 4;
	localparam int unsigned EV_MISMATCH = 5;
	localparam logic [1:0] WD_SEL_OFF = 2'h3;
	localparam logic [1:0] WD_SEL_SHORT = 2'h2;
	localparam logic [3:0] ADDR_BITS = 4'h8;
	typedef enum logic [1:0] {WD_IDLE = 2'h0, WD_RUN = 2'h1, WD_TOUT = 2'h3} cst_wd_t;
	typedef enum logic [1:0] {BUS_IDLE = 2'h0, BUS_ADDR = 2'h1, BUS_ACT = 2'h3} cst_bus_t;
endpackage

/* hw/cst_supervisor.sv */
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module cst_supervisor #(
	parameter int TW = 24,
	parameter logic [TW-1:0] POR_0 = TW'(cst_pkg::POR_CYC_0),
	parameter logic [TW-1:0] POR_1 = TW'(cst_pkg::POR_CYC_1),
	parameter logic [TW-1:0] POR_2 = TW'(cst_pkg::POR_CYC_2),
	parameter logic [TW-1:0] POR_3 = TW'(cst_pkg::POR_CYC_3),
	parameter logic [TW-1:0] WD_0 = TW'(cst_pkg::WD_CYC_0),
	parameter logic [TW-1:0] WD_1 = TW'(cst_pkg::WD_CYC_1),
	parameter logic [TW-1:0] WD_2 = TW'(cst_pkg::WD_CYC_2),
	parameter logic [TW-1:0] TOUT_LONG = TW'(cst_pkg::TOUT_LONG_CYC),
	parameter logic [TW-1:0] TOUT_SHORT = TW'(cst_pkg::TOUT_SHORT_CYC),
	parameter logic [TW-1:0] NV_TIME = TW'(cst_pkg::NV_CYC),
	parameter logic [3:0] DEV_SEL = 4'ha // Arbitrary device select code
) (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	input wire logic supply_ok_in, // Primary above trip
	input wire logic second_ok_in, // Second above trip
	input wire logic manual_reset_in, // Manual reset, high
	input wire logic wdog_restart_in, // Watchdog restart pin
	input wire logic scl_in, // Serial clock pin
	input wire logic sda_in, // Serial data pin
	output logic reset_out, // Host reset, high
	output logic supply_low_warning, // Early power-fail
	output logic second_supply_fail, // Second supply low
	output logic wdog_timeout_out, // Watchdog fired
	output logic irq // Level interrupt
);
	// Register decode used for both read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	logic sup_s, sec_s, mr_s, wdr_s, scl_s, sda_s;
	logic scl_d, sda_d, wdr_d, sup_d, sec_d;
	logic [3:0] ctrl;
	logic [cst_pkg::EV_W-1:0] status, mask, ev, next_status;
	logic [2:0] pd_cnt, mr_cnt;
	logic [TW-1:0] por_val, por_cnt, wd_val, wd_cnt, nv_cnt;
	logic por_done, wd_done, nv_done, nv_busy_d;
	logic wd_load, mr_active, pd_reset, sys_rst;
	cst_pkg::cst_wd_t wd_state, next_wd;
	cst_pkg::cst_bus_t bus_state, next_bus;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic rw;

	// All pins cross into pclk through two flops
	cst_sync #(.W(6)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({supply_ok_in, second_ok_in, manual_reset_in, wdog_restart_in, scl_in, sda_in}),
		.q({sup_s, sec_s, mr_s, wdr_s, scl_s, sda_s})
	);

	// Edge history, taken after the synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_d, sda_d, wdr_d, sup_d, sec_d} <= 5'h00;
		end else begin
			{scl_d, sda_d, wdr_d, sup_d, sec_d} <= {scl_s, sda_s, wdr_s, sup_s, sec_s};
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	wire restart = wdr_s & ~wdr_d;

	// APB decode
	wire setup = psel & ~penable;
	wire addr_ok = hit(paddr, cst_pkg::CTRL_OFF) | hit(paddr, cst_pkg::STATUS_OFF) |
		hit(paddr, cst_pkg::MASK_OFF) | hit(paddr, cst_pkg::STATE_OFF);
	wire wr_en = psel & penable & pready & pwrite & addr_ok;
	wire wr_ctrl = wr_en & hit(paddr, cst_pkg::CTRL_OFF);
	wire wr_status = wr_en & hit(paddr, cst_pkg::STATUS_OFF);
	wire wr_mask = wr_en & hit(paddr, cst_pkg::MASK_OFF);
	wire [31:0] state_word = {23'h000000, bus_state, wd_state, nv_busy_d, wdog_timeout_out,
		second_supply_fail, supply_low_warning, reset_out};
	wire [31:0] rd_data = hit(paddr, cst_pkg::CTRL_OFF) ? {28'h0000000, ctrl} :
		hit(paddr, cst_pkg::STATUS_OFF) ? {26'h0000000, status} :
		hit(paddr, cst_pkg::MASK_OFF) ? {26'h0000000, mask} :
		hit(paddr, cst_pkg::STATE_OFF) ? state_word : 32'h00000000;

	// Zero-wait slave: answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~addr_ok;
			prdata <= (setup & ~pwrite) ? rd_data : 32'h00000000;
		end
	end

	// Control and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= cst_pkg::CTRL_RESET;
			mask <= '0;
		end else begin
			if (wr_ctrl) ctrl <= pwdata[3:0];
			if (wr_mask) mask <= pwdata[cst_pkg::EV_W-1:0];
		end
	end

	wire [1:0] por_sel = {ctrl[cst_pkg::POR_SEL_HI_BIT], ctrl[cst_pkg::POR_SEL_LO_BIT]};
	wire [1:0] wd_sel = {ctrl[cst_pkg::WD_SEL_HI_BIT], ctrl[cst_pkg::WD_SEL_LO_BIT]};
	wire wd_off = (wd_sel == cst_pkg::WD_SEL_OFF);

	// Power-on delay selection
	assign por_val = (por_sel == 2'h0) ? POR_0 : (por_sel == 2'h1) ? POR_1 :
		(por_sel == 2'h2) ? POR_2 : POR_3;

	// Held loaded while the supply is low, counts from the rise
	cst_timer #(.W(TW)) u_por (
		.clk(pclk),
		.rst_n(presetn),
		.load(~sup_s),
		.load_val(por_val),
		.count(por_cnt),
		.done(por_done)
	);

	// Power-down: warning first, reset a fixed lead later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_cnt <= cst_pkg::WARN_LEAD_CYC;
		end else if (sup_s) begin
			pd_cnt <= 3'h0;
		end else if (pd_cnt != cst_pkg::WARN_LEAD_CYC) begin
			pd_cnt <= pd_cnt + 3'h1;
		end
	end
	assign pd_reset = (pd_cnt == cst_pkg::WARN_LEAD_CYC);

	// Manual reset must stay high for the whole count; a glitch restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr_cnt <= 3'h0;
		end else if (!mr_s) begin
			mr_cnt <= 3'h0;
		end else if (mr_cnt != cst_pkg::MR_CYC) begin
			mr_cnt <= mr_cnt + 3'h1;
		end
	end
	assign mr_active = (mr_cnt == cst_pkg::MR_CYC);

	assign sys_rst = pd_reset | (sup_s & ~por_done) | mr_active;

	// Watchdog sequencing; one timer serves period and time-out
	always_comb begin
		next_wd = wd_state;
		wd_load = 1'b0;
		wd_val = (wd_sel == 2'h0) ? WD_0 : (wd_sel == 2'h1) ? WD_1 : WD_2;
		case (wd_state)
			cst_pkg::WD_IDLE: begin
				if (!wd_off && !sys_rst) begin
					next_wd = cst_pkg::WD_RUN;
					wd_load = 1'b1;
				end
			end
			cst_pkg::WD_RUN: begin
				if (wd_off || sys_rst) begin
					next_wd = cst_pkg::WD_IDLE;
				end else if (restart) begin
					wd_load = 1'b1;
				end else if (wd_done) begin
					next_wd = cst_pkg::WD_TOUT;
					wd_load = 1'b1;
					wd_val = (wd_sel == cst_pkg::WD_SEL_SHORT) ? TOUT_SHORT :
						TOUT_LONG;
				end
			end
			cst_pkg::WD_TOUT: begin
				// Time-out runs to its end even if software turns the watchdog off
				if (wd_done) next_wd = cst_pkg::WD_IDLE;
			end
			default: next_wd = cst_pkg::WD_IDLE;
		endcase
	end

	cst_timer #(.W(TW)) u_wd (
		.clk(pclk),
		.rst_n(presetn),
		.load(wd_load),
		.load_val(wd_val),
		.count(wd_cnt),
		.done(wd_done)
	);

	// Two-wire observer: address shift and bit count
	wire addr_last = (bus_state == cst_pkg::BUS_ADDR) & scl_rise & (bitcnt == cst_pkg::ADDR_BITS);
	wire addr_match = (shreg[7:4] == DEV_SEL);
	wire nv_start = stop_cond & (bus_state == cst_pkg::BUS_ACT) & ~rw;

	always_comb begin
		next_bus = bus_state;
		case (bus_state)
			cst_pkg::BUS_IDLE: if (start_cond && nv_done) next_bus = cst_pkg::BUS_ADDR;
			cst_pkg::BUS_ADDR: begin
				if (stop_cond) next_bus = cst_pkg::BUS_IDLE;
				else if (addr_last) next_bus = addr_match ? cst_pkg::BUS_ACT :
					cst_pkg::BUS_IDLE;
			end
			cst_pkg::BUS_ACT: begin
				if (stop_cond) next_bus = cst_pkg::BUS_IDLE;
				else if (start_cond) next_bus = cst_pkg::BUS_ADDR;
			end
			default: next_bus = cst_pkg::BUS_IDLE;
		endcase
	end

	// Address bits are counted from each start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			rw <= 1'b0;
		end else if (start_cond) begin
			bitcnt <= 4'h0;
		end else if (bus_state == cst_pkg::BUS_ADDR && scl_rise) begin
			if (bitcnt != cst_pkg::ADDR_BITS) begin
				shreg <= {shreg[6:0], sda_s};
				bitcnt <= bitcnt + 4'h1;
			end else begin
				rw <= shreg[0];
			end
		end
	end

	// Self-timed write; bus requests ignored meanwhile
	cst_timer #(.W(TW)) u_nv (
		.clk(pclk),
		.rst_n(presetn),
		.load(nv_start),
		.load_val(NV_TIME),
		.count(nv_cnt),
		.done(nv_done)
	);

	// Sticky events; a set in the clearing cycle wins
	assign ev[cst_pkg::EV_WDOG] = (next_wd == cst_pkg::WD_TOUT) & (wd_state == cst_pkg::WD_RUN);
	assign ev[cst_pkg::EV_MANUAL] = mr_s & (mr_cnt == cst_pkg::MR_CYC - 3'h1);
	assign ev[cst_pkg::EV_SUPPLY_LOW_WARNING] = sup_d & ~sup_s;
	assign ev[cst_pkg::EV_SECOND] = sec_d & ~sec_s;
	assign ev[cst_pkg::EV_NV_DONE] = nv_busy_d & nv_done;
	assign ev[cst_pkg::EV_MISMATCH] = addr_last & ~addr_match;
	assign next_status = (status & ~(wr_status ? pwdata[cst_pkg::EV_W-1:0] : '0)) | ev;

	// State registers and pin outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_state <= cst_pkg::WD_IDLE;
			bus_state <= cst_pkg::BUS_IDLE;
			status <= '0;
			irq <= 1'b0;
			nv_busy_d <= 1'b0;
			reset_out <= 1'b1;
			supply_low_warning <= 1'b1;
			second_supply_fail <= 1'b1;
			wdog_timeout_out <= 1'b0;
		end else begin
			wd_state <= next_wd;
			bus_state <= next_bus;
			status <= next_status;
			irq <= |(next_status & mask);
			nv_busy_d <= ~nv_done;
			reset_out <= sys_rst | (next_wd == cst_pkg::WD_TOUT);
			supply_low_warning <= ~sup_s;
			second_supply_fail <= ~sec_s;
			wdog_timeout_out <= (next_wd == cst_pkg::WD_TOUT);
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_warn_only;
		supply_low_warning && !reset_out;
	endsequence
	sequence s_reset_follows;
		##[4:6] reset_out;
	endsequence

	a_por_delay_load: assert property ($rose(sup_s) |-> por_cnt == por_val)
		else $error("power-on delay not loaded with selected value");
	a_por_hold_reset: assert property ($rose(sup_s) && !por_done |=> reset_out [*4])
		else $error("reset released before power-on delay");
	a_wdog_off_idle: assert property (wd_off && wd_state != cst_pkg::WD_TOUT
		|=> wd_state == cst_pkg::WD_IDLE)
		else $error("watchdog running while disabled");
	a_wdog_long_tout: assert property (wd_state == cst_pkg::WD_RUN && wd_done && !restart
		&& !sys_rst && !wd_off && wd_sel != cst_pkg::WD_SEL_SHORT
		|=> wd_cnt == TOUT_LONG ##1 reset_out)
		else $error("long time-out not started");
	a_wdog_short_tout: assert property (wd_state == cst_pkg::WD_RUN && wd_done && !restart
		&& !sys_rst && wd_sel == cst_pkg::WD_SEL_SHORT
		|=> wd_cnt == TOUT_SHORT ##1 wdog_timeout_out)
		else $error("short time-out not started");
	a_wdog_restart_reload: assert property (wd_state == cst_pkg::WD_RUN && restart
		&& !sys_rst && !wd_off |=> wd_cnt == $past(wd_val))
		else $error("restart did not reload watchdog");
	a_mr_no_early: assert property ($rose(mr_active) |-> $past(mr_s, 4)
		&& $past(mr_s, 1))
		else $error("manual reset acted too soon");
	a_mr_glitch_drop: assert property (mr_s ##1 !mr_s |=> !mr_active)
		else $error("short manual pulse caused reset");
	a_warn_leads: assert property ($fell(sup_s) && !reset_out && !mr_active
		&& wd_state != cst_pkg::WD_TOUT |=> s_warn_only ##0 s_reset_follows)
		else $error("warning and reset out of order");
	a_second_fail: assert property (!sec_s |=> second_supply_fail)
		else $error("second supply fail not flagged");
	a_nv_busy_hold: assert property (nv_start |=> !nv_done [*8])
		else $error("write cycle ended early");
	a_bus_standby: assert property (addr_last && !addr_match && !stop_cond
		|=> bus_state == cst_pkg::BUS_IDLE)
		else $error("no standby after device select mismatch");

	// Checked after the synchroniser, so pin skew is not judged here
	a_warn_low: assert property (!sup_s |=> supply_low_warning)
		else $error("supply warning not raised");
	a_pd_reset_out: assert property (pd_reset |=> reset_out)
		else $error("power-down reset not raised");
	a_wdog_tout_hold: assert property (wd_state == cst_pkg::WD_TOUT && !wd_done
		|=> wdog_timeout_out && reset_out)
		else $error("time-out outputs dropped early");
	a_status_set_wins: assert property (ev != '0 |=> (status & $past(ev)) == $past(ev))
		else $error("event lost in clearing cycle");
	a_irq_level: assert property (1'b1 |=> irq == |(status & $past(mask)))
		else $error("interrupt level wrong");
	a_apb_one_cycle: assert property (pready |=> !pready)
		else $error("ready held beyond one cycle");
endmodule

/* hw/cst_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module cst_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Async reset, low
	input wire logic [W-1:0] d, // Raw pins
	output logic [W-1:0] q // Synchronised levels
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* hw/cst_timer.sv */
`timescale 1ns/1ps
// Loadable down-counter, stops at zero
module cst_timer #(
	parameter int W = 24
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset, low
	input wire logic load, // Load pulse or level
	input wire logic [W-1:0] load_val, // Value to load
	output logic [W-1:0] count, // Remaining cycles
	output logic done // Count reached zero
);
	assign done = (count == '0);

	// Load wins over counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (load) begin
			count <= load_val;
		end else if (!done) begin
			count <= count - 1'b1;
		end
	end
endmodule

/* tb/cst_host_model.sv */
`timescale 1ns/1ps
// Host side: watchdog restarts and two-wire frames
module cst_host_model (
	input wire logic pclk, // Bus clock
	output logic scl_in, // Serial clock, idles high
	output logic sda_in, // Serial data, pulled high
	output logic wdog_restart_in // Watchdog restart
);
	// Host never programs thresholds: no program voltage on the watchdog pin
	// Bus lines rest at their pull-up level
	initial begin
		scl_in = 1'b1;
		sda_in = 1'b1;
		wdog_restart_in = 1'b0;
	end

	// Half of the 800 ns serial clock
	task automatic half();
		repeat (4) @(posedge pclk);
	endtask

	// High and low for 1 us each, the shortest pulse the host may give
	task automatic kick();
		@(posedge pclk);
		wdog_restart_in <= 1'b1;
		repeat (10) @(posedge pclk);
		wdog_restart_in <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask

	// Start, address byte MSB first, ninth clock released, then stop
	task automatic frame(input logic [7:0] b);
		@(posedge pclk);
		sda_in <= 1'b0;
		half();
		for (int i = 8; i >= 0; i--) begin
			scl_in <= 1'b0;
			repeat (2) @(posedge pclk);
			// Data moves only while the clock is low, so no false start
			sda_in <= (i > 0) ? b[i-1] : 1'b1;
			repeat (2) @(posedge pclk);
			scl_in <= 1'b1;
			half();
		end
		scl_in <= 1'b0;
		repeat (2) @(posedge pclk);
		sda_in <= 1'b0;
		repeat (2) @(posedge pclk);
		scl_in <= 1'b1;
		half();
		sda_in <= 1'b1;
		half();
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam int POR_T[4] = '{60, 80, 100, 120};
	localparam int WD_T[3] = '{300, 200, 150};
	localparam int TO_T[3] = '{90, 90, 40};
	localparam int NV_T = 50;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic supply_ok_in, second_ok_in, manual_reset_in, wdog_restart_in, scl_in, sda_in;
	logic reset_out, supply_low_warning, second_supply_fail, wdog_timeout_out;
	int n_mismatch = 0;
	int tests_run = 0;
	int n, s;
	time t0;

	cst_supervisor #(.POR_0(POR_T[0][23:0]), .POR_1(POR_T[1][23:0]), .POR_2(POR_T[2][23:0]),
		.POR_3(POR_T[3][23:0]), .WD_0(WD_T[0][23:0]), .WD_1(WD_T[1][23:0]),
		.WD_2(WD_T[2][23:0]), .TOUT_LONG(TO_T[0][23:0]), .TOUT_SHORT(TO_T[2][23:0]),
		.NV_TIME(NV_T[23:0])) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok_in(supply_ok_in),
		.second_ok_in(second_ok_in), .manual_reset_in(manual_reset_in),
		.wdog_restart_in(wdog_restart_in), .scl_in(scl_in), .sda_in(sda_in),
		.reset_out(reset_out), .supply_low_warning(supply_low_warning),
		.second_supply_fail(second_supply_fail), .wdog_timeout_out(wdog_timeout_out), .irq(irq));

	cst_host_model HOST (.pclk(pclk), .scl_in(scl_in), .sda_in(sda_in),
		.wdog_restart_in(wdog_restart_in));

	// 10 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// A count outside its window is reported against the lower bound
	task automatic rng(input int v, input int lo, input int hi);
		chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
	endtask

	// Full APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) chk(32'h0, 32'h1);
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return reset_out;
			1: return supply_low_warning;
			2: return second_supply_fail;
			default: return wdog_timeout_out;
		endcase
	endfunction

	// Edges until an output reaches a level, bounded
	task automatic cnt(input int w, input logic lvl, output int v);
		v = 0;
		while (pick(w) !== lvl && v < 3000) begin
			@(posedge pclk);
			#1;
			v++;
		end
	endtask

	// Hang guard, well beyond the planned run
	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{supply_ok_in, second_ok_in, manual_reset_in} = 3'b110;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		cnt(0, 1'b0, n);
		rng(n, POR_T[1], POR_T[1] + 6);
		apb(1'b0, cst_pkg::CTRL_OFF, 32'h0);
		chk(rd, 32'hd);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h00000000, e}, 32'h00000001);
		chk(rd, 32'h00000000);
		// Every delay select, with a supply drop before each power-up
		for (s = 0; s < 4; s++) begin
			apb(1'b1, cst_pkg::CTRL_OFF, {28'h0, 2'b11, 2'(s)});
			@(posedge pclk);
			supply_ok_in <= 1'b0;
			#1;
			cnt(1, 1'b1, n);
			rng(n, 0, 50);
			cnt(0, 1'b1, n);
			chk(32'(n), 32'(cst_pkg::WARN_LEAD_CYC));
			@(posedge pclk);
			supply_ok_in <= 1'b1;
			#1;
			cnt(0, 1'b0, n);
			rng(n, POR_T[s], POR_T[s] + 6);
		end
		// One-cycle blip on manual reset must not reach the host
		@(posedge pclk);
		manual_reset_in <= 1'b1;
		@(posedge pclk);
		manual_reset_in <= 1'b0;
		repeat (20) @(posedge pclk);
		#1;
		chk(reset_out, 1'b0);
		manual_reset_in <= 1'b1;
		#1;
		cnt(0, 1'b1, n);
		rng(n, 5, 12);
		@(posedge pclk);
		manual_reset_in <= 1'b0;
		#1;
		cnt(0, 1'b0, n);
		rng(n, 0, 6);
		// Interrupt raised, cleared, then masked
		apb(1'b1, cst_pkg::MASK_OFF, 32'h3f);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
		chk(rd, 32'h6);
		apb(1'b1, cst_pkg::STATUS_OFF, 32'h3f);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		second_ok_in <= 1'b0;
		#1;
		cnt(2, 1'b1, n);
		rng(n, 0, 50);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
		chk(rd, 32'h8);
		apb(1'b1, cst_pkg::MASK_OFF, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		second_ok_in <= 1'b1;
		// Each enabled period left to expire, watchdog off in between
		for (s = 2; s >= 0; s--) begin
			apb(1'b1, cst_pkg::CTRL_OFF, {28'h0, 2'(s), 2'b01});
			#1;
			cnt(3, 1'b1, n);
			rng(n, WD_T[s] - 2, WD_T[s] + 8);
			chk(reset_out, 1'b1);
			cnt(3, 1'b0, n);
			rng(n, TO_T[s] - 2, TO_T[s] + 4);
			apb(1'b1, cst_pkg::CTRL_OFF, 32'hd);
		end
		// Restarts every 100 cycles keep a 200-cycle watchdog quiet
		apb(1'b1, cst_pkg::STATUS_OFF, 32'h3f);
		apb(1'b1, cst_pkg::CTRL_OFF, 32'h5);
		repeat (4) begin
			HOST.kick();
			repeat (80) @(posedge pclk);
		end
		apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
		chk(rd[0], 1'b0);
		#1;
		cnt(3, 1'b1, n);
		rng(n, 85, 112);
		apb(1'b1, cst_pkg::CTRL_OFF, 32'hd);
		apb(1'b1, cst_pkg::STATUS_OFF, 32'h3f);
		repeat (400) @(posedge pclk);
		apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
		chk(rd[0], 1'b0);
		// Wrong device select, then a matching write frame
		HOST.frame(8'h50);
		apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
		chk(rd, 32'h20);
		apb(1'b0, cst_pkg::STATE_OFF, 32'h0);
		chk(rd[8:7], 2'h0);
		HOST.frame(8'ha0);
		t0 = $time;
		apb(1'b0, cst_pkg::STATE_OFF, 32'h0);
		chk(rd[4], 1'b1);
		n = 0;
		// Host polls for completion instead of waiting the full time
		do begin
			apb(1'b0, cst_pkg::STATUS_OFF, 32'h0);
			n++;
		end while (rd[4] !== 1'b1 && n < 100);
		rng(int'(($time - t0) / 100), 40, 62);
		// A read frame must leave the write cycle idle and the bus in standby
		HOST.frame(8'ha1);
		apb(1'b0, cst_pkg::STATE_OFF, 32'h0);
		chk(rd[8:4], 5'h00);
		give_verdict();
	end
endmodule
